// [include/rca_pkg.sv]
// package for the calendar, alarm and event block
package rca_pkg;
    localparam logic [11:0] CALENDAR_VALUE_OFF = 12'h00C;
    localparam logic [11:0] TIME_ALARM_OFF = 12'h010;
    localparam logic [11:0] CALENDAR_ALARM_OFF = 12'h014;
    localparam logic [11:0] EVENT_STATUS_OFF = 12'h018;
    localparam logic [11:0] EVENT_CLEAR_OFF = 12'h01C;
    localparam logic [11:0] IRQ_ENABLE_SET_OFF = 12'h020;
    localparam logic [11:0] IRQ_DISABLE_SET_OFF = 12'h024;
    localparam logic [11:0] IRQ_MASK_VIEW_OFF = 12'h028;
    localparam logic [11:0] TIME_VALUE_OFF = 12'h030;
    localparam logic [11:0] EVENT_CONTROL_OFF = 12'h034;

    localparam logic [31:0] CALENDAR_VALUE_RST = 32'h01819819;
    localparam logic [31:0] TIME_ALARM_RST = 32'h00000000;
    localparam logic [31:0] CALENDAR_ALARM_RST = 32'h00000000;
    localparam logic [31:0] TIME_VALUE_RST = 32'h00000000;

    // status bit positions
    localparam int ST_GRANT = 0;
    localparam int ST_ALARM = 1;
    localparam int ST_SEC = 2;
    localparam int ST_CLKEV = 3;
    localparam int ST_CALENDAR_EVENT_FLAG = 4;
    localparam int ST_W = 5;

    // calendar_value fields
    localparam int CAL_HUNDRED_YEAR_FIELD_LO = 0;
    localparam int CAL_YEAR_LO = 8;
    localparam int CAL_MONTH_LO = 16;
    localparam int CAL_DAY_LO = 21;
    localparam int CAL_DATE_LO = 24;
    // time_alarm fields
    localparam int TA_S_EN = 7;
    localparam int TA_M_EN = 15;
    localparam int TA_PM = 22;
    localparam int TA_H_EN = 23;
    // calendar_alarm fields
    localparam int CA_MONTH_EN = 23;
    localparam int CA_DOM_EN = 31;
    // event_control fields
    localparam int EC_HOLD_CLK = 0;
    localparam int EC_HOLD_CAL = 1;
    localparam int EC_CLKSEL_LO = 8;
    localparam int EC_CALSEL_LO = 16;

    localparam logic [1:0] CLKSEL_MINUTE = 2'h0;
    localparam logic [1:0] CLKSEL_HOUR = 2'h1;
    localparam logic [1:0] CLKSEL_MIDNIGHT = 2'h2;
    localparam logic [1:0] CLKSEL_NOON = 2'h3;
    localparam logic [1:0] CALSEL_WEEK = 2'h0;
    localparam logic [1:0] CALSEL_MONTH = 2'h1;

    localparam logic [7:0] BCD_NOON = 8'h12;
    localparam logic [5:0] BCD_DATE_FIRST = 6'h01;
    localparam logic [4:0] BCD_MONTH_JAN = 5'h01;
    localparam logic [2:0] DAY_MONDAY = 3'h1;
    localparam logic [5:0] DATE_MIN = 6'h01;
    localparam logic [5:0] DATE_MAX = 6'h31;
    localparam logic [4:0] MONTH_MIN = 5'h01;
    localparam logic [4:0] MONTH_MAX = 5'h12;
    localparam logic [2:0] DAY_MIN = 3'h1;
    localparam logic [2:0] DAY_MAX = 3'h7;
    localparam logic [6:0] HUNDRED_YEAR_FIELD_MIN = 7'h19;
    localparam logic [6:0] HUNDRED_YEAR_FIELD_MAX = 7'h20;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } rca_apb_rsp_t;

    typedef struct packed {
        logic sec_tick;
        logic min_chg;
        logic hour_chg;
        logic day_chg;
        logic week_chg;
        logic month_chg;
        logic year_chg;
    } rca_tick_t;
endpackage

// [design/rca_calendar_events.sv]
// calendar, alarm, event status and interrupt mask logic with apb slave
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module rca_calendar_events (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // counter events and current values from the time base
    input wire rca_pkg::rca_tick_t tick,
    input wire logic [31:0] time_now,
    input wire logic [31:0] cal_now,
    // to the counters, and the interrupt out
    output logic [31:0] calendar_value,
    output logic cal_load,
    output logic hold_clock_request,
    output logic hold_calendar_request,
    output logic irq
);
    typedef struct packed {
        logic [31:0] cal;
        logic [31:0] talarm;
        logic [31:0] calarm;
        logic [31:0] ctrl;
        logic [rca_pkg::ST_W-1:0] status;
        logic [rca_pkg::ST_W-1:0] mask;
        logic alarm_hit;
        logic cal_load;
        logic irq;
        rca_pkg::rca_apb_rsp_t rsp;
    } rca_state_t;

    rca_state_t st_q, st_d;

    function automatic logic acc(input logic [11:0] a, input logic [11:0] o);
        acc = psel && penable && (a == o);
    endfunction

    function automatic logic bcd_ok(input logic [7:0] v);
        bcd_ok = (v[3:0] < 4'hA) && (v[7:4] < 4'hA);
    endfunction

    logic [6:0] w_hundred_year_field;
    logic [7:0] w_year;
    logic [4:0] w_month;
    logic [2:0] w_day;
    logic [5:0] w_date;
    logic cal_ok;
    logic [31:0] cal_eff;
    logic match_s, match_m, match_h, match_mo, match_d, alarm_now;
    logic clk_ev, cal_ev;
    logic [rca_pkg::ST_W-1:0] ev_set, clr;
    logic wr, grant;

    assign wr = psel && penable && pwrite;

    assign w_hundred_year_field = pwdata[rca_pkg::CAL_HUNDRED_YEAR_FIELD_LO +: 7];
    assign w_year = pwdata[rca_pkg::CAL_YEAR_LO +: 8];
    assign w_month = pwdata[rca_pkg::CAL_MONTH_LO +: 5];
    assign w_day = pwdata[rca_pkg::CAL_DAY_LO +: 3];
    assign w_date = pwdata[rca_pkg::CAL_DATE_LO +: 6];
    assign cal_ok = w_hundred_year_field >= rca_pkg::HUNDRED_YEAR_FIELD_MIN
        && w_hundred_year_field <= rca_pkg::HUNDRED_YEAR_FIELD_MAX
        && bcd_ok({1'b0, w_hundred_year_field}) && bcd_ok(w_year)
        && w_month >= rca_pkg::MONTH_MIN && w_month <= rca_pkg::MONTH_MAX
        && bcd_ok({3'h0, w_month})
        && w_day >= rca_pkg::DAY_MIN && w_day <= rca_pkg::DAY_MAX
        && w_date >= rca_pkg::DATE_MIN && w_date <= rca_pkg::DATE_MAX
        && bcd_ok({2'h0, w_date});

    // grant once a hold is requested
    assign grant = st_q.ctrl[rca_pkg::EC_HOLD_CLK]
        | st_q.ctrl[rca_pkg::EC_HOLD_CAL];

    // shown value follows counters unless software owns it
    assign cal_eff = st_q.ctrl[rca_pkg::EC_HOLD_CAL] ? st_q.cal : cal_now;

    assign match_s = !st_q.talarm[rca_pkg::TA_S_EN]
        || st_q.talarm[6:0] == time_now[6:0];
    assign match_m = !st_q.talarm[rca_pkg::TA_M_EN]
        || st_q.talarm[14:8] == time_now[14:8];
    assign match_h = !st_q.talarm[rca_pkg::TA_H_EN]
        || st_q.talarm[rca_pkg::TA_PM:16] == time_now[rca_pkg::TA_PM:16];
    assign match_mo = !st_q.calarm[rca_pkg::CA_MONTH_EN]
        || st_q.calarm[20:16] == cal_now[20:16];
    assign match_d = !st_q.calarm[rca_pkg::CA_DOM_EN]
        || st_q.calarm[29:24] == cal_now[29:24];
    assign alarm_now = match_s && match_m && match_h && match_mo && match_d
        && (st_q.talarm[rca_pkg::TA_S_EN] || st_q.talarm[rca_pkg::TA_M_EN]
        || st_q.talarm[rca_pkg::TA_H_EN]
        || st_q.calarm[rca_pkg::CA_MONTH_EN]
        || st_q.calarm[rca_pkg::CA_DOM_EN]);

    always_comb begin
        case (st_q.ctrl[rca_pkg::EC_CLKSEL_LO +: 2])
            rca_pkg::CLKSEL_MINUTE: clk_ev = tick.min_chg;
            rca_pkg::CLKSEL_HOUR: clk_ev = tick.hour_chg;
            rca_pkg::CLKSEL_MIDNIGHT: clk_ev = tick.day_chg;
            default: clk_ev = tick.hour_chg
                && time_now[21:16] == rca_pkg::BCD_NOON[5:0];
        endcase
    end

    always_comb begin
        case (st_q.ctrl[rca_pkg::EC_CALSEL_LO +: 2])
            rca_pkg::CALSEL_WEEK: cal_ev = tick.week_chg;
            rca_pkg::CALSEL_MONTH: cal_ev = tick.month_chg;
            default: cal_ev = tick.year_chg;
        endcase
    end

    always_comb begin
        ev_set = '0;
        ev_set[rca_pkg::ST_GRANT] = grant;
        ev_set[rca_pkg::ST_ALARM] = alarm_now && !st_q.alarm_hit;
        ev_set[rca_pkg::ST_SEC] = tick.sec_tick;
        ev_set[rca_pkg::ST_CLKEV] = clk_ev;
        ev_set[rca_pkg::ST_CALENDAR_EVENT_FLAG] = cal_ev;
        clr = '0;
        if (wr && paddr == rca_pkg::EVENT_CLEAR_OFF) begin
            clr = pwdata[rca_pkg::ST_W-1:0];
        end
    end

    always_comb begin
        st_d = st_q;
        st_d.rsp.pready = 1'b0;
        st_d.rsp.pslverr = 1'b0;
        st_d.cal_load = 1'b0;
        st_d.alarm_hit = alarm_now;
        // set wins over clear
        st_d.status = (st_q.status & ~clr) | ev_set;
        if (!grant) begin
            st_d.status[rca_pkg::ST_GRANT] = 1'b0;
        end
        if (!st_q.ctrl[rca_pkg::EC_HOLD_CAL]) begin
            st_d.cal = cal_now;
        end
        if (psel && !penable) begin
            st_d.rsp.pready = 1'b1;
            st_d.rsp.prdata = 32'h00000000;
            if (paddr == rca_pkg::CALENDAR_VALUE_OFF) begin
                st_d.rsp.prdata = cal_eff;
            end else if (paddr == rca_pkg::TIME_ALARM_OFF) begin
                st_d.rsp.prdata = st_q.talarm;
            end else if (paddr == rca_pkg::CALENDAR_ALARM_OFF) begin
                st_d.rsp.prdata = st_q.calarm;
            end else if (paddr == rca_pkg::EVENT_STATUS_OFF) begin
                st_d.rsp.prdata[rca_pkg::ST_W-1:0] = st_q.status;
            end else if (paddr == rca_pkg::IRQ_MASK_VIEW_OFF) begin
                st_d.rsp.prdata[rca_pkg::ST_W-1:0] = st_q.mask;
            end else if (paddr == rca_pkg::EVENT_CONTROL_OFF) begin
                st_d.rsp.prdata = st_q.ctrl;
            end else if (paddr == rca_pkg::EVENT_CLEAR_OFF
                || paddr == rca_pkg::IRQ_ENABLE_SET_OFF
                || paddr == rca_pkg::IRQ_DISABLE_SET_OFF) begin
                st_d.rsp.prdata = 32'h00000000;
            end else begin
                st_d.rsp.pslverr = 1'b1;
            end
        end
        if (wr) begin
            if (paddr == rca_pkg::CALENDAR_VALUE_OFF) begin
                // writes only land while hold is granted
                if (st_q.status[rca_pkg::ST_GRANT]
                    && st_q.ctrl[rca_pkg::EC_HOLD_CAL] && cal_ok) begin
                    st_d.cal = pwdata & 32'h3FFFFF7F;
                    st_d.cal_load = 1'b1;
                end
            end else if (paddr == rca_pkg::TIME_ALARM_OFF) begin
                st_d.talarm = pwdata & 32'h00FFFF7F;
                st_d.talarm[rca_pkg::TA_S_EN] = pwdata[rca_pkg::TA_S_EN];
            end else if (paddr == rca_pkg::CALENDAR_ALARM_OFF) begin
                st_d.calarm = pwdata & 32'hBF9F0000;
            end else if (paddr == rca_pkg::IRQ_ENABLE_SET_OFF) begin
                st_d.mask = st_q.mask | pwdata[rca_pkg::ST_W-1:0];
            end else if (paddr == rca_pkg::IRQ_DISABLE_SET_OFF) begin
                st_d.mask = st_q.mask & ~pwdata[rca_pkg::ST_W-1:0];
            end else if (paddr == rca_pkg::EVENT_CONTROL_OFF) begin
                st_d.ctrl = pwdata & 32'h00030303;
            end
        end
        st_d.irq = |(st_d.status & st_d.mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= '0;
            st_q.cal <= rca_pkg::CALENDAR_VALUE_RST;
            st_q.talarm <= rca_pkg::TIME_ALARM_RST;
            st_q.calarm <= rca_pkg::CALENDAR_ALARM_RST;
        end else begin
            st_q <= st_d;
        end
    end

    assign prdata = st_q.rsp.prdata;
    assign pready = st_q.rsp.pready;
    assign pslverr = st_q.rsp.pslverr;
    assign calendar_value = st_q.cal;
    assign cal_load = st_q.cal_load;
    assign hold_clock_request = st_q.ctrl[rca_pkg::EC_HOLD_CLK];
    assign hold_calendar_request = st_q.ctrl[rca_pkg::EC_HOLD_CAL];
    assign irq = st_q.irq;

    // clear without event drops the bit
    AST_CLEAR_WORKS: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == rca_pkg::EVENT_CLEAR_OFF
        && pwdata[rca_pkg::ST_SEC] && !tick.sec_tick
        |=> !st_q.status[rca_pkg::ST_SEC])
        else $error("seconds flag not cleared");
    AST_SEC_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        tick.sec_tick ##1 !clr[rca_pkg::ST_SEC] |=> st_q.status[rca_pkg::ST_SEC])
        else $error("seconds flag lost");
    AST_ALARM_SET: assert property (@(posedge pclk) disable iff (!presetn)
        alarm_now && !st_q.alarm_hit |=> st_q.status[rca_pkg::ST_ALARM])
        else $error("alarm flag missing");
    AST_CLKEV_SET: assert property (@(posedge pclk) disable iff (!presetn)
        clk_ev |=> st_q.status[rca_pkg::ST_CLKEV])
        else $error("clock event flag missing");
    AST_CALENDAR_EVENT_FLAG_SET: assert property (@(posedge pclk) disable iff (!presetn)
        cal_ev |=> st_q.status[rca_pkg::ST_CALENDAR_EVENT_FLAG])
        else $error("calendar event flag missing");
    AST_MASK_SET: assert property (@(posedge pclk) disable iff (!presetn)
        wr && paddr == rca_pkg::IRQ_ENABLE_SET_OFF && pwdata[rca_pkg::ST_SEC]
        |=> st_q.mask[rca_pkg::ST_SEC])
        else $error("mask bit not set");
    AST_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
        irq == |(st_q.status & st_q.mask))
        else $error("irq mismatch");
    AST_GRANT: assert property (@(posedge pclk) disable iff (!presetn)
        !grant |=> !st_q.status[rca_pkg::ST_GRANT])
        else $error("grant without request");
endmodule
`default_nettype wire

// [tb/tb_top.sv]
// self-checking bench for the calendar, alarm and event block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    rca_pkg::rca_tick_t tick;
    rca_pkg::rca_tick_t tk;
    logic [31:0] time_now;
    logic [31:0] cal_now;
    logic [31:0] calendar_value;
    logic cal_load;
    logic hold_clock_request;
    logic hold_calendar_request;
    logic irq;
    logic [31:0] rdat;
    logic rerr;
    logic [31:0] bad [2] = '{32'h31F39920, 32'h31E59921};
    int error_cnt;
    int n_checks;

    rca_calendar_events DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .tick(tick),
        .time_now(time_now), .cal_now(cal_now),
        .calendar_value(calendar_value), .cal_load(cal_load),
        .hold_clock_request(hold_clock_request),
        .hold_calendar_request(hold_calendar_request), .irq(irq)
    );

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    task automatic results();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic chk_bit(input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    // one apb transfer, waits for pready under a bound
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            results();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h00000000);
        chk(exp, rdat);
    endtask

    task automatic pulse(input rca_pkg::rca_tick_t t);
        @(posedge pclk);
        tick <= t;
        @(posedge pclk);
        tick <= '0;
        repeat (3) @(posedge pclk);
    endtask

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h00000000;
        tick = '0;
        time_now = 32'h00000000;
        cal_now = rca_pkg::CALENDAR_VALUE_RST;
        error_cnt = 0;
        n_checks = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(rca_pkg::CALENDAR_VALUE_OFF, 32'h01819819);
        rd_chk(rca_pkg::TIME_ALARM_OFF, 32'h00000000);
        rd_chk(rca_pkg::CALENDAR_ALARM_OFF, 32'h00000000);
        rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000000);
        rd_chk(rca_pkg::IRQ_MASK_VIEW_OFF, 32'h00000000);
        apb(1'b0, rca_pkg::TIME_VALUE_OFF, 32'h00000000);
        chk_bit(1'b1, rerr);
        wr(rca_pkg::EVENT_STATUS_OFF, 32'h0000001F);
        rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000000);
        wr(rca_pkg::TIME_ALARM_OFF, 32'h00D185B0);
        rd_chk(rca_pkg::TIME_ALARM_OFF, 32'h00D185B0);
        wr(rca_pkg::CALENDAR_ALARM_OFF, 32'hB1850000);
        rd_chk(rca_pkg::CALENDAR_ALARM_OFF, 32'hB1850000);
        // calendar write refused without grant, then under hold
        wr(rca_pkg::CALENDAR_VALUE_OFF, 32'h31E59920);
        @(negedge pclk);
        chk_bit(1'b0, cal_load);
        rd_chk(rca_pkg::CALENDAR_VALUE_OFF, 32'h01819819);
        wr(rca_pkg::EVENT_CONTROL_OFF, 32'h00000003);
        rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000001);
        chk_bit(1'b1, hold_clock_request);
        chk_bit(1'b1, hold_calendar_request);
        for (int i = 0; i < 2; i++) begin
            wr(rca_pkg::CALENDAR_VALUE_OFF, bad[i]);
            @(negedge pclk);
            chk_bit(1'b0, cal_load);
            rd_chk(rca_pkg::CALENDAR_VALUE_OFF, 32'h01819819);
        end
        wr(rca_pkg::CALENDAR_VALUE_OFF, 32'h31E59920);
        @(negedge pclk);
        chk_bit(1'b1, cal_load);
        rd_chk(rca_pkg::CALENDAR_VALUE_OFF, 32'h31E59920);
        chk(32'h31E59920, calendar_value);
        cal_now <= 32'h31E59920;
        wr(rca_pkg::EVENT_CONTROL_OFF, 32'h00000000);
        rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000000);
        // alarm: minute mismatch first, then full match
        time_now <= 32'h00510030;
        repeat (3) @(posedge pclk);
        rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000000);
        time_now <= 32'h00510530;
        repeat (3) @(posedge pclk);
        time_now <= 32'h00000000;
        rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000002);
        wr(rca_pkg::EVENT_CLEAR_OFF, 32'h00000002);
        rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000000);
        // second event and interrupt mask
        wr(rca_pkg::IRQ_ENABLE_SET_OFF, 32'h00000004);
        rd_chk(rca_pkg::IRQ_MASK_VIEW_OFF, 32'h00000004);
        chk_bit(1'b0, irq);
        tk = '0;
        tk.sec_tick = 1'b1;
        pulse(tk);
        rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000004);
        chk_bit(1'b1, irq);
        wr(rca_pkg::EVENT_CLEAR_OFF, 32'h0000001B);
        rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000004);
        wr(rca_pkg::IRQ_DISABLE_SET_OFF, 32'h00000004);
        rd_chk(rca_pkg::IRQ_MASK_VIEW_OFF, 32'h00000000);
        chk_bit(1'b0, irq);
        wr(rca_pkg::EVENT_CLEAR_OFF, 32'h00000004);
        rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000000);
        // noon selected, hour change at hour zero gives nothing
        wr(rca_pkg::EVENT_CONTROL_OFF, 32'h00000300);
        tk = '0;
        tk.hour_chg = 1'b1;
        pulse(tk);
        rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000000);
        for (int s = 0; s < 4; s++) begin
            wr(rca_pkg::EVENT_CONTROL_OFF, 32'(s) << 8);
            tk = '0;
            tk.min_chg = (s == 0);
            tk.hour_chg = (s == 1 || s == 3);
            tk.day_chg = (s == 2);
            time_now <= (s == 3) ? 32'h00120000 : 32'h00000000;
            pulse(tk);
            rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000008);
            wr(rca_pkg::EVENT_CLEAR_OFF, 32'h00000008);
        end
        for (int s = 0; s < 4; s++) begin
            wr(rca_pkg::EVENT_CONTROL_OFF, 32'(s) << 16);
            tk = '0;
            tk.week_chg = (s == 0);
            tk.month_chg = (s == 1);
            tk.year_chg = (s >= 2);
            pulse(tk);
            rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000010);
            wr(rca_pkg::EVENT_CLEAR_OFF, 32'h00000010);
        end
        rd_chk(rca_pkg::EVENT_STATUS_OFF, 32'h00000000);
        results();
    end
endmodule
`default_nettype wire
